// *** src/rsc_pkg.sv ***
// How it works
// - Register bus only when the option is enabled.
// - Reset polarity fixed by a build parameter.
// - Built for one selected managed device type.
// - Build-selected arbitration for the shared port.
// - Fetch depth power of two, 16..131072, limited.
// - Fetch storage is block or distributed memory.
// - Two to six sync stages; four-plus need depth 32.
// - Status stream only when status option enabled.
// - Control stream only when control option enabled.
// - Start-in-shutdown socket leaves reset in shutdown.
// - Shutdown-on-error socket shuts down on any error.
// - Leaving reset full and active, run module startup steps.
// - Skip option suppresses startup steps after reset.
// - Record power-on module; mandatory on one device type.
// - Module storage rounded up to power of two.
// - Software startup notification precedes module reset.
// - Full socket after reset asserts module reset.
// - Module reset held configured cycles, at most 256.
package rsc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FIFO_DATA = 8'h08;
  localparam logic [7:0] OFS_MOD_TABLE = 8'h0c;
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_ID_LSB = 8;
  localparam int STAT_FULL_BIT = 5;
  localparam int STAT_ERR_BIT = 6;
  localparam int STAT_SWREQ_BIT = 7;
  localparam int STAT_FIFO_FULL_BIT = 8;
  localparam int STAT_MOD_LSB = 9;
  localparam int TBL_ENTRY_LSB = 8;
  localparam int MAX_RESET_CYCLES = 256;
  localparam int DEV_TYPE_A = 0;
  localparam int DEV_TYPE_CLEARING = 1;
  localparam int DEV_TYPE_C = 2;
  localparam int ARB_NONE = 0;
  localparam int ARB_REQ_GNT = 1;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_RESTART = 3'h2;
  localparam logic [2:0] CMD_LOAD = 3'h3;
  localparam logic [2:0] CMD_LOAD_DONE = 3'h4;
  localparam logic [2:0] CMD_SW_ACK = 3'h5;
  localparam logic [2:0] CMD_RST_ON = 3'h6;
  localparam logic [2:0] CMD_RST_OFF = 3'h7;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'b00001,
    ST_SHUT = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_SWSTART = 5'b01000,
    ST_MRESET = 5'b10000
  } rsc_state_t;

  typedef struct packed {
    logic rst_low;
    logic rst_en;
    logic sw_start;
  } rsc_mod_entry_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic [6:0] id;
  } rsc_cmd_t;
endpackage : rsc_pkg

// *** src/rsc_fetch_fifo.sv ***
module rsc_fetch_fifo
  import rsc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter bit USE_BLOCK_RAM = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic mem_empty;
  logic push;
  logic pop;

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign mem_empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  generate
    if (USE_BLOCK_RAM) begin : g_block
      // Block memory needs a registered read, so one output stage sits here.
      logic out_valid_reg;
      logic [WIDTH-1:0] out_data_reg;
      assign pop = !mem_empty && (!out_valid_reg || out_ready_i);
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          out_valid_reg <= 1'b0;
        end else if (pop) begin
          out_valid_reg <= 1'b1;
        end else if (out_ready_i) begin
          out_valid_reg <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys_i) begin
        if (pop) begin
          out_data_reg <= mem[rd_ptr_reg[AW-1:0]];
        end
      end
      assign out_valid_o = out_valid_reg;
      assign out_data_o = out_data_reg;
      assign empty_o = mem_empty && !out_valid_reg;
    end else begin : g_dist
      assign pop = !mem_empty && out_ready_i;
      assign out_valid_o = !mem_empty;
      assign out_data_o = mem[rd_ptr_reg[AW-1:0]];
      assign empty_o = mem_empty;
    end
  endgenerate
endmodule : rsc_fetch_fifo

// *** src/rsc_socket_ctrl.sv ***
// Register access over APB and the placing of the registers were decided locally.
module rsc_socket_ctrl
  import rsc_pkg::*;
#(
  parameter bit HAS_REG_IF = 1'b1,
  parameter bit RESET_ACTIVE_LEVEL = 1'b0,
  parameter int DEVICE_TYPE = DEV_TYPE_A,
  parameter int ARB_PROTOCOL = ARB_NONE,
  parameter bit COMPRESSED = 1'b0,
  parameter int FIFO_DEPTH = 64,
  parameter bit FIFO_BLOCK_RAM = 1'b1,
  parameter int CDC_STAGES = 2,
  parameter bit HAS_STATUS_CH = 1'b1,
  parameter bit HAS_CTRL_CH = 1'b1,
  parameter bit START_IN_SHUTDOWN = 1'b0,
  parameter bit SHUTDOWN_ON_ERROR = 1'b0,
  parameter bit SKIP_STARTUP = 1'b0,
  parameter bit HAS_POR_MODULE = 1'b1,
  parameter logic [6:0] POR_MODULE = 7'h00,
  parameter int MODULES_ALLOC = 2,
  parameter logic [2:0] MOD_ENTRY_DEFAULT = 3'h2,
  parameter int RESET_CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ctrl_tvalid_i,
  output logic ctrl_tready_o,
  input wire logic [31:0] ctrl_tdata_i,
  output logic stat_tvalid_o,
  input wire logic stat_tready_i,
  output logic [31:0] stat_tdata_o,
  output logic cfg_req_o,
  input wire logic cfg_gnt_i,
  output logic cfg_valid_o,
  input wire logic cfg_ready_i,
  output logic [31:0] cfg_data_o,
  input wire logic cfg_err_i,
  output logic module_reset_out_o,
  output logic sw_start_req_o
);
  localparam int SLOTS = 2 ** $clog2(MODULES_ALLOC);
  localparam int SW = $clog2(SLOTS);
  // The power-on module is compulsory on the clearing-bitstream device.
  localparam bit POR_FULL = HAS_POR_MODULE ||
                            (DEVICE_TYPE == DEV_TYPE_CLEARING);

  generate
    if (FIFO_DEPTH < 16 || FIFO_DEPTH > 131072 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fetch fifo depth must be a power of two in range");
    end
    if (CDC_STAGES < 2 || CDC_STAGES > 6) begin : g_bad_cdc
      $error("sync stage count out of range");
    end
    if (CDC_STAGES > 3 && FIFO_DEPTH < 32) begin : g_bad_mix
      $error("four or more sync stages need depth of 32");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES > MAX_RESET_CYCLES) begin : g_bad_rst
      $error("module reset duration out of range");
    end
  endgenerate

  logic rst;
  assign rst = (rstn_i == RESET_ACTIVE_LEVEL);

  rsc_state_t state_reg;
  rsc_mod_entry_t mod_tbl_reg [SLOTS];
  rsc_mod_entry_t cur_entry;
  logic [6:0] cur_mod_reg;
  logic full_reg;
  logic err_reg;
  logic boot_reg;
  logic done_req_reg;
  logic man_rst_reg;
  logic [8:0] rst_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic ctrl_tready_reg;
  logic stat_tvalid_reg;
  logic [31:0] stat_tdata_reg;
  logic cfg_req_reg;
  logic cfg_valid_reg;
  logic [31:0] cfg_data_reg;
  logic mod_rst_reg;
  rsc_state_t state_seen_reg;

  assign cur_entry = mod_tbl_reg[cur_mod_reg[SW-1:0]];

  // APB slave: one wait state, longer while a data word meets a full FIFO.
  logic apb_acc;
  logic apb_done;
  logic addr_ok;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic fifo_empty;
  logic fifo_push;
  logic data_stall;
  logic [31:0] status_word;
  assign apb_acc = psel_i && penable_i && HAS_REG_IF;
  assign addr_ok = paddr_i == OFS_CTRL || paddr_i == OFS_STATUS ||
                   paddr_i == OFS_FIFO_DATA || paddr_i == OFS_MOD_TABLE;
  assign data_stall = pwrite_i && paddr_i == OFS_FIFO_DATA &&
                      state_reg == ST_LOAD && !fifo_in_ready;
  assign apb_done = apb_acc && pready_reg;
  assign fifo_push = apb_done && pwrite_i && !pslverr_reg &&
                     paddr_i == OFS_FIFO_DATA && state_reg == ST_LOAD;
  assign status_word = {16'h0000, cur_mod_reg, fifo_empty,
                        sw_start_req_o, err_reg, full_reg, state_reg};

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apb_acc && !pready_reg && !data_stall;
      pslverr_reg <= apb_acc && !pready_reg && !addr_ok;
      if (apb_acc && !pready_reg && !pwrite_i) begin
        unique case (paddr_i)
          OFS_CTRL: prdata_reg <= {25'h0000000, cur_mod_reg};
          OFS_STATUS: prdata_reg <= status_word;
          OFS_MOD_TABLE: prdata_reg <= {29'h0000000, cur_entry};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command source: bus writes win over the control stream in a tie.
  rsc_cmd_t cmd;
  logic cmd_valid;
  logic bus_cmd;
  logic strm_cmd;
  assign bus_cmd = apb_done && pwrite_i && paddr_i == OFS_CTRL;
  assign strm_cmd = HAS_CTRL_CH && ctrl_tvalid_i && ctrl_tready_reg;
  assign cmd_valid = bus_cmd || strm_cmd;
  assign cmd = bus_cmd ?
    {pwdata_i[CTRL_CMD_LSB +: 3], pwdata_i[CTRL_ID_LSB +: 7]} :
    {ctrl_tdata_i[CTRL_CMD_LSB +: 3], ctrl_tdata_i[CTRL_ID_LSB +: 7]};

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      ctrl_tready_reg <= 1'b0;
    end else begin
      ctrl_tready_reg <= HAS_CTRL_CH && !bus_cmd;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        mod_tbl_reg[i] <= MOD_ENTRY_DEFAULT;
      end
    end else if (apb_done && pwrite_i && paddr_i == OFS_MOD_TABLE) begin
      mod_tbl_reg[pwdata_i[SW-1:0]] <= pwdata_i[TBL_ENTRY_LSB +: 3];
    end
  end

  // Socket sequencer.
  logic load_finish;
  logic startup_go;
  assign load_finish = done_req_reg && fifo_empty && !cfg_valid_reg;
  assign startup_go = load_finish ||
                      (boot_reg && full_reg && !SKIP_STARTUP);

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      state_reg <= START_IN_SHUTDOWN ? ST_SHUT : ST_ACTIVE;
      boot_reg <= !START_IN_SHUTDOWN;
      full_reg <= POR_FULL;
      cur_mod_reg <= POR_MODULE;
      done_req_reg <= 1'b0;
      man_rst_reg <= 1'b0;
      rst_cnt_reg <= 9'h000;
    end else begin
      boot_reg <= 1'b0;
      if (cfg_err_i && SHUTDOWN_ON_ERROR) begin
        state_reg <= ST_SHUT;
        done_req_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_ACTIVE, ST_SHUT: begin
            if (cmd_valid && cmd.cmd == CMD_LOAD) begin
              state_reg <= ST_LOAD;
              full_reg <= 1'b0;
              cur_mod_reg <= cmd.id;
              man_rst_reg <= 1'b0;
            end else if (state_reg == ST_ACTIVE && startup_go) begin
              // Software hears of the module before its reset is pulsed.
              if (cur_entry.sw_start) begin
                state_reg <= ST_SWSTART;
              end else if (cur_entry.rst_en) begin
                state_reg <= ST_MRESET;
                rst_cnt_reg <= 9'(RESET_CYCLES);
              end
            end else if (cmd_valid && cmd.cmd == CMD_SHUTDOWN) begin
              state_reg <= ST_SHUT;
            end else if (cmd_valid && cmd.cmd == CMD_RESTART) begin
              state_reg <= ST_ACTIVE;
              man_rst_reg <= 1'b0;
            end else if (state_reg == ST_SHUT && cmd_valid) begin
              man_rst_reg <= (cmd.cmd == CMD_RST_ON) ? 1'b1 :
                             (cmd.cmd == CMD_RST_OFF) ? 1'b0 : man_rst_reg;
            end
          end
          ST_LOAD: begin
            if (load_finish) begin
              full_reg <= 1'b1;
              done_req_reg <= 1'b0;
              if (cur_entry.sw_start) begin
                state_reg <= ST_SWSTART;
              end else if (cur_entry.rst_en) begin
                state_reg <= ST_MRESET;
                rst_cnt_reg <= 9'(RESET_CYCLES);
              end else begin
                state_reg <= ST_ACTIVE;
              end
            end else if (cmd_valid && cmd.cmd == CMD_LOAD_DONE) begin
              done_req_reg <= 1'b1;
            end
          end
          ST_SWSTART: begin
            if (cmd_valid && cmd.cmd == CMD_SW_ACK) begin
              state_reg <= cur_entry.rst_en ? ST_MRESET : ST_ACTIVE;
              rst_cnt_reg <= 9'(RESET_CYCLES);
            end
          end
          ST_MRESET: begin
            rst_cnt_reg <= rst_cnt_reg - 9'h001;
            if (rst_cnt_reg == 9'h001) begin
              state_reg <= ST_ACTIVE;
            end
          end
          default: state_reg <= ST_SHUT;
        endcase
      end
    end
  end

  // Set wins over the bus clear of the error flag.
  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (cfg_err_i) begin
      err_reg <= 1'b1;
    end else if (apb_done && pwrite_i && paddr_i == OFS_STATUS &&
                 pwdata_i[STAT_ERR_BIT]) begin
      err_reg <= 1'b0;
    end
  end

  // The module reset level follows the loaded module's polarity.
  logic rst_assert;
  assign rst_assert = state_reg == ST_MRESET ||
                      (state_reg == ST_SHUT && man_rst_reg);
  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      mod_rst_reg <= MOD_ENTRY_DEFAULT[2];
    end else begin
      mod_rst_reg <= rst_assert ^ cur_entry.rst_low;
    end
  end

  // Status stream: each state change is reported; a pending word is
  // overwritten by a newer one, so only the latest state is guaranteed.
  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      stat_tvalid_reg <= 1'b0;
      stat_tdata_reg <= 32'h0000_0000;
      state_seen_reg <= START_IN_SHUTDOWN ? ST_SHUT : ST_ACTIVE;
    end else if (HAS_STATUS_CH) begin
      state_seen_reg <= state_reg;
      if (state_reg != state_seen_reg) begin
        stat_tvalid_reg <= 1'b1;
        stat_tdata_reg <= status_word;
      end else if (stat_tready_i) begin
        stat_tvalid_reg <= 1'b0;
      end
    end
  end

  // Port side: words leave the FIFO only while the shared port is ours; a word already on the port is held until taken.
  logic granted;
  logic fifo_pop;

  rsc_fetch_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .USE_BLOCK_RAM(FIFO_BLOCK_RAM)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pwdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .empty_o(fifo_empty)
  );

  assign granted = (ARB_PROTOCOL == ARB_NONE) || cfg_gnt_i;
  assign fifo_pop = granted && (!cfg_valid_reg || cfg_ready_i);
  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      cfg_req_reg <= 1'b0;
      cfg_valid_reg <= 1'b0;
      cfg_data_reg <= 32'h0000_0000;
    end else begin
      cfg_req_reg <= (ARB_PROTOCOL == ARB_REQ_GNT) &&
                     (state_reg == ST_LOAD || !fifo_empty);
      if (fifo_pop) begin
        cfg_valid_reg <= fifo_out_valid;
        cfg_data_reg <= fifo_out_data;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign ctrl_tready_o = ctrl_tready_reg;
  assign stat_tvalid_o = stat_tvalid_reg;
  assign stat_tdata_o = stat_tdata_reg;
  assign cfg_req_o = cfg_req_reg;
  assign cfg_valid_o = cfg_valid_reg;
  assign cfg_data_o = cfg_data_reg;
  assign module_reset_out_o = mod_rst_reg;
  // The state is one-hot, so the wait flag is one state flip-flop.
  assign sw_start_req_o = state_reg[$clog2(ST_SWSTART)];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst);

  logic [8:0] hold_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst || state_reg != ST_MRESET) begin
      hold_cnt_reg <= 9'h000;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 9'h001;
    end
  end

  reset_len_a: assert property (
    hold_cnt_reg <= 9'(RESET_CYCLES)) else $error("module reset too long");
  sw_first_a: assert property (
    $rose(state_reg == ST_MRESET) && cur_entry.sw_start |->
    $past(state_reg) == ST_SWSTART) else $error("reset before notice");
  err_shut_a: assert property (
    cfg_err_i && SHUTDOWN_ON_ERROR |=> state_reg == ST_SHUT)
    else $error("no shutdown on error");
  boot_state_a: assert property (
    boot_reg |-> state_reg == ST_ACTIVE && !START_IN_SHUTDOWN)
    else $error("wrong state after reset");
  boot_skip_a: assert property (
    boot_reg && SKIP_STARTUP |=> state_reg == ST_ACTIVE)
    else $error("startup ran despite skip");
  boot_rst_a: assert property (
    boot_reg && full_reg && !SKIP_STARTUP && cur_entry.rst_en &&
    !cur_entry.sw_start |=> state_reg == ST_MRESET ##1
    module_reset_out_o != cur_entry.rst_low)
    else $error("no module reset at boot");
  grant_out_a: assert property (
    ARB_PROTOCOL == ARB_REQ_GNT && fifo_pop && fifo_out_valid |->
    cfg_gnt_i) else $error("word sent without grant");
  apb_ready_a: assert property (
    apb_acc && !pready_reg && !data_stall |=> pready_o ##1 !pready_o)
    else $error("bus answer not timed");
  stat_quiet_a: assert property (
    !HAS_STATUS_CH |-> !stat_tvalid_o) else $error("status not gated");

  load_c: cover property (state_reg == ST_LOAD ##[1:200] cfg_valid_o);
  reset_c: cover property ($rose(state_reg == ST_MRESET));
  swstart_c: cover property (state_reg == ST_SWSTART ##1
    state_reg != ST_SWSTART);
  shut_c: cover property (cfg_err_i ##1 state_reg == ST_SHUT);
endmodule : rsc_socket_ctrl

// *** dv/rsc_cfgport_model.sv ***
module rsc_cfgport_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cfg_req_i,
  output logic cfg_gnt_o,
  input wire logic cfg_valid_i,
  output logic cfg_ready_o,
  input wire logic [31:0] cfg_data_i,
  output logic cfg_err_o,
  input wire logic slow_i,
  input wire logic err_pulse_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words [$];
  logic [1:0] cnt_reg;

  // In slow mode ready is offered one cycle in four, so the sender must hold.
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_reg <= 2'h0;
      cfg_ready_o <= 1'b0;
      cfg_gnt_o <= 1'b0;
      cfg_err_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      cfg_ready_o <= !slow_i || (cnt_reg == 2'h3);
      cfg_gnt_o <= cfg_req_i;
      cfg_err_o <= err_pulse_i;
      if (cfg_valid_i && cfg_ready_o) begin
        words.push_back(cfg_data_i);
      end
    end
  end
endmodule : rsc_cfgport_model

// *** dv/tb_top.sv ***
module tb_top;
  import rsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 4;
  logic clk_sys_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, ctdata, stdata, cdata, q;
  logic ctvalid, ctready, stvalid, creq, cgnt, cvalid, cready, cerr;
  logic mrst, swreq, slow, errp, e;
  int n_fail, num_checks, run, rlen, nstat, nbad;
  logic [31:0] expw [3];

  rsc_socket_ctrl #(.SHUTDOWN_ON_ERROR(1'b1), .RESET_CYCLES(RC),
    .ARB_PROTOCOL(ARB_REQ_GNT)) dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ctrl_tvalid_i(ctvalid),
    .ctrl_tready_o(ctready), .ctrl_tdata_i(ctdata),
    .stat_tvalid_o(stvalid), .stat_tready_i(1'b1),
    .stat_tdata_o(stdata), .cfg_req_o(creq), .cfg_gnt_i(cgnt),
    .cfg_valid_o(cvalid), .cfg_ready_i(cready), .cfg_data_o(cdata),
    .cfg_err_i(cerr), .module_reset_out_o(mrst), .sw_start_req_o(swreq));

  rsc_cfgport_model part_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_req_i(creq),
    .cfg_gnt_o(cgnt), .cfg_valid_i(cvalid), .cfg_ready_o(cready),
    .cfg_data_i(cdata), .cfg_err_o(cerr), .slow_i(slow),
    .err_pulse_i(errp));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Length of the last module reset pulse, counted in whole cycles.
  always @(posedge clk_sys_i) begin
    if (mrst === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) rlen <= run;
      run <= 0;
    end
    if (stvalid === 1'b1) nstat <= nstat + 1;
    if (cvalid === 1'b1 && cgnt !== 1'b1) nbad <= nbad + 1;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ctl(input logic [2:0] c, input logic [6:0] id);
    int n;
    @(posedge clk_sys_i);
    ctvalid <= 1'b1;
    ctdata <= {17'h0, id, 5'h0, c};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ctready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
    ctvalid <= 1'b0;
  endtask : ctl

  task automatic wst(input logic [4:0] ex);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[4:0] !== ex && n < 40);
    chk("state", {27'h0, ex}, {27'h0, q[4:0]});
  endtask : wst

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, ctvalid, slow, errp} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctdata = 32'h0;
    {n_fail, num_checks, run, rlen, nstat, nbad} = '0;
    expw = '{32'h0a0b0c0d, 32'hffff0000, 32'h00000001};
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    wst(5'h01);
    chk("boot reset len", RC, rlen);
    chk("full", 32'h1, {31'h0, q[STAT_FULL_BIT]});
    ctl(CMD_SHUTDOWN, 7'h0);
    wst(5'h02);
    chk("stat seen", 32'h1, {31'h0, nstat > 0});
    apb(1'b1, OFS_CTRL, {29'h0, CMD_RESTART});
    wst(5'h01);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, OFS_MOD_TABLE, 32'h00000301);
    apb(1'b1, OFS_CTRL, {17'h0, 7'h01, 5'h0, CMD_LOAD});
    wst(5'h04);
    slow <= 1'b1;
    rlen = 0;
    foreach (expw[i]) apb(1'b1, OFS_FIFO_DATA, expw[i]);
    apb(1'b1, OFS_CTRL, {29'h0, CMD_LOAD_DONE});
    wst(5'h08);
    chk("sw req", 32'h1, {31'h0, swreq});
    chk("no reset yet", 32'h0, {31'h0, mrst});
    chk("word count", 32'h3, part_u.words.size());
    foreach (expw[i]) chk("cfg word", expw[i], part_u.words[i]);
    chk("ungranted word", 32'h0, nbad);
    apb(1'b1, OFS_CTRL, {29'h0, CMD_SW_ACK});
    wst(5'h01);
    // The pulse length lands two edges after the state leaves reset.
    @(posedge clk_sys_i);
    chk("load reset len", RC, rlen);
    chk("module id", 32'h1, {25'h0, q[15:9]});
    @(posedge clk_sys_i);
    errp <= 1'b1;
    @(posedge clk_sys_i);
    errp <= 1'b0;
    wst(5'h02);
    chk("err flag", 32'h1, {31'h0, q[STAT_ERR_BIT]});
    apb(1'b1, OFS_STATUS, 32'h00000040);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("err clear", 32'h0, {31'h0, q[STAT_ERR_BIT]});
    summarize();
  end
endmodule : tb_top
